// ===== two_wire_serial_flash_port.sv
// device side of a sector flash reached over a clock pin and one data pin
// assumes the link clock and data pin are synchronous to mclk and slower than it
`timescale 1ns/1ns
module two_wire_serial_flash_port #(
    parameter int SECTORS = two_wire_flash_pkg::SMALL_SECTORS,
    parameter int PROGRAM_CYC = two_wire_flash_pkg::PROGRAM_CYC,
    parameter int FIFO_DEPTH = 16,
    parameter logic [15:0] DEVICE_ID = 16'h5a01 // arbitrary identity value
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic sck,
    input wire logic bidirDataPinIn,
    output logic bidirDataPinOut,
    output logic bidirDataPinOe,
    input wire logic [3:0] deviceSelectStraps,
    output logic busy
);
    // ========================================
    // derived sizes
    localparam int SB = two_wire_flash_pkg::SECTOR_BYTES;
    localparam int ADDR_W = $clog2(SECTORS * SB);
    localparam int BUSY_W = $clog2(PROGRAM_CYC + 1);
    localparam logic [4:0] HDR_LAST = 5'(two_wire_flash_pkg::HEADER_BITS - 1);
    localparam logic [4:0] STAT_LAST = 5'(two_wire_flash_pkg::STATUS_BITS - 1);
    localparam logic [4:0] BYTE_LAST = 5'(two_wire_flash_pkg::BYTE_BITS - 1);
    localparam logic [9:0] LAST_BYTE = 10'(SB - 1);
    localparam logic [9:0] SECTOR_LEN = 10'(SB);
    localparam logic [4:0] RESET_LOW = 5'(two_wire_flash_pkg::RESET_CYC);
    localparam logic [BUSY_W-1:0] BUSY_LOAD = BUSY_W'(PROGRAM_CYC);
    localparam logic [15:0] FIRST_COPY = 16'(SECTORS - 2);
    localparam logic [15:0] SECTOR_COUNT = 16'(SECTORS);

    // ========================================
    // functions
    function automatic logic [ADDR_W-1:0] byteAddr(input logic [15:0] sector, input logic [9:0] idx);
        byteAddr = ADDR_W'(32'(sector) * 32'(SB) + 32'(idx));
    endfunction

    // info contents: tag, identity, empty restricted list
    function automatic logic [7:0] infoByte(input logic [9:0] idx);
        case (idx)
            10'h000: infoByte = two_wire_flash_pkg::SECTOR_TAG;
            10'h001: infoByte = DEVICE_ID[15:8];
            10'h002: infoByte = DEVICE_ID[7:0];
            default: infoByte = two_wire_flash_pkg::BLANK_BYTE;
        endcase
    endfunction

    // ========================================
    // state
    two_wire_flash_pkg::link_state_e state, next_state;
    two_wire_flash_pkg::header_s hdr, next_hdr, shiftedHdr;
    logic sckPrev;
    logic sckRise;
    logic [4:0] lowCnt, next_lowCnt;
    logic linkReset;
    logic [4:0] bitCnt, next_bitCnt;
    logic [9:0] byteCnt, next_byteCnt;
    logic [15:0] shiftOut, next_shiftOut;
    logic [7:0] inByte, next_inByte;
    logic next_oe;
    logic [BUSY_W-1:0] busyCnt, next_busyCnt;
    logic memWe;
    logic [7:0] memData;
    logic fillStart, popReq;
    logic [9:0] rdIdx, next_rdIdx;
    logic filling, next_filling;
    logic fifoInValid, fifoInReady, fifoOutValid;
    logic [7:0] fifoInData, fifoOutData;
    logic sectorWritable, infoSel;
    logic [7:0] flash [SECTORS * SB];

    // every sector starts life carrying the tag byte
    initial begin
        for (int s = 0; s < SECTORS; s++) begin
            flash[s * SB] = two_wire_flash_pkg::SECTOR_TAG;
        end
    end

    // ========================================
    // link clock edge and clock-low reset detection
    assign sckRise = sck && !sckPrev;
    assign linkReset = !sck && (lowCnt == RESET_LOW);
    assign busy = (busyCnt != '0);
    assign shiftedHdr = {hdr[22:0], bidirDataPinIn};
    // the info sector and its copies are never programmable
    assign sectorWritable = (hdr.sector < FIRST_COPY);
    assign infoSel = (hdr.sector == two_wire_flash_pkg::INFO_SECTOR) || (hdr.sector >= FIRST_COPY && hdr.sector < SECTOR_COUNT);

    // low counter saturates one past the threshold so the reset fires once
    always_comb begin
        if (sck) begin
            next_lowCnt = '0;
        end else if (lowCnt > RESET_LOW) begin
            next_lowCnt = lowCnt;
        end else begin
            next_lowCnt = 5'(lowCnt + 1'b1);
        end
    end

    // ========================================
    // sequence state machine
    always_comb begin
        next_state = state;
        next_hdr = hdr;
        next_bitCnt = bitCnt;
        next_byteCnt = byteCnt;
        next_shiftOut = shiftOut;
        next_inByte = inByte;
        next_busyCnt = busy ? BUSY_W'(busyCnt - 1'b1) : busyCnt;
        memWe = 1'b0;
        memData = {inByte[6:0], bidirDataPinIn};
        fillStart = 1'b0;
        popReq = 1'b0;
        if (linkReset) begin
            // a write's busy time starts when its sequence is closed by the reset; its bytes were stored as they arrived
            if (state == two_wire_flash_pkg::sWriteData) begin
                next_busyCnt = BUSY_LOAD;
            end
            next_state = two_wire_flash_pkg::sStandby;
            next_bitCnt = '0;
        end else if (sckRise) begin
            // no rising edge means a paused sequence: nothing moves
            case (state)
                two_wire_flash_pkg::sStandby: begin
                    next_state = two_wire_flash_pkg::sHeader;
                    next_bitCnt = '0;
                end
                two_wire_flash_pkg::sHeader: begin
                    next_hdr = shiftedHdr;
                    next_bitCnt = 5'(bitCnt + 1'b1);
                    if (bitCnt == HDR_LAST) begin
                        next_bitCnt = '0;
                        next_byteCnt = '0;
                        if (shiftedHdr.deviceSelectField != deviceSelectStraps) begin
                            next_state = two_wire_flash_pkg::sIgnore;
                        end else if (shiftedHdr.cmd == two_wire_flash_pkg::CMD_READ) begin
                            next_state = two_wire_flash_pkg::sStatus;
                            next_shiftOut = busy ? two_wire_flash_pkg::STATUS_BUSY
                                                 : two_wire_flash_pkg::STATUS_READY;
                            fillStart = !busy;
                        end else if (shiftedHdr.cmd == two_wire_flash_pkg::CMD_WRITE && !busy) begin
                            next_state = two_wire_flash_pkg::sWriteData;
                        end else begin
                            next_state = two_wire_flash_pkg::sIgnore;
                        end
                    end
                end
                two_wire_flash_pkg::sStatus: begin
                    next_shiftOut = {shiftOut[14:0], 1'b0};
                    next_bitCnt = 5'(bitCnt + 1'b1);
                    if (bitCnt == STAT_LAST) begin
                        next_bitCnt = '0;
                        // a busy device refuses the read after reporting status
                        if (busy) begin
                            next_state = two_wire_flash_pkg::sIgnore;
                        end else begin
                            next_state = two_wire_flash_pkg::sReadData;
                            next_shiftOut = {fifoOutData, 8'h00};
                            popReq = 1'b1;
                        end
                    end
                end
                two_wire_flash_pkg::sReadData: begin
                    next_shiftOut = {shiftOut[14:0], 1'b0};
                    next_bitCnt = 5'(bitCnt + 1'b1);
                    if (bitCnt == BYTE_LAST) begin
                        next_bitCnt = '0;
                        next_byteCnt = 10'(byteCnt + 1'b1);
                        if (byteCnt == LAST_BYTE) begin
                            next_state = two_wire_flash_pkg::sIgnore;
                        end else begin
                            next_shiftOut = {fifoOutData, 8'h00};
                            popReq = 1'b1;
                        end
                    end
                end
                two_wire_flash_pkg::sWriteData: begin
                    next_inByte = {inByte[6:0], bidirDataPinIn};
                    next_bitCnt = 5'(bitCnt + 1'b1);
                    if (bitCnt == BYTE_LAST) begin
                        next_bitCnt = '0;
                        // bytes past the sector end are dropped; unsent ones keep stale data
                        if (byteCnt < SECTOR_LEN) begin
                            memWe = sectorWritable;
                            next_byteCnt = 10'(byteCnt + 1'b1);
                        end
                    end
                end
                default: begin
                    next_state = state;
                end
            endcase
        end
        // drive only through status and data of a matched read
        next_oe = (next_state == two_wire_flash_pkg::sStatus) || (next_state == two_wire_flash_pkg::sReadData);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= two_wire_flash_pkg::sStandby;
            hdr <= '0;
            sckPrev <= 1'b0;
            lowCnt <= '0;
            bitCnt <= '0;
            byteCnt <= '0;
            shiftOut <= '0;
            inByte <= '0;
            bidirDataPinOe <= 1'b0;
            busyCnt <= '0;
        end else begin
            state <= next_state;
            hdr <= next_hdr;
            sckPrev <= sck;
            lowCnt <= next_lowCnt;
            bitCnt <= next_bitCnt;
            byteCnt <= next_byteCnt;
            shiftOut <= next_shiftOut;
            inByte <= next_inByte;
            bidirDataPinOe <= next_oe;
            busyCnt <= next_busyCnt;
        end
    end

    // launched bit is the top of the shifter, so it changes right after each rise
    assign bidirDataPinOut = shiftOut[15];

    // ========================================
    // array write port
    always_ff @(posedge mclk) begin
        if (memWe) begin
            flash[byteAddr(hdr.sector, byteCnt)] <= memData;
        end
    end

    // ========================================
    // read prefetch: fills the fifo ahead of the link, stalls when it is full
    always_comb begin
        next_rdIdx = rdIdx;
        next_filling = filling;
        if (linkReset) begin
            next_filling = 1'b0;
        end else if (fillStart) begin
            next_filling = 1'b1;
            next_rdIdx = '0;
        end else if (fifoInValid && fifoInReady) begin
            next_rdIdx = 10'(rdIdx + 1'b1);
            next_filling = (rdIdx != LAST_BYTE);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdIdx <= '0;
            filling <= 1'b0;
        end else begin
            rdIdx <= next_rdIdx;
            filling <= next_filling;
        end
    end

    assign fifoInValid = filling;
    // unmapped sectors read blank; info and its copies come from constants
    always_comb begin
        if (infoSel) begin
            fifoInData = infoByte(rdIdx);
        end else if (hdr.sector < SECTOR_COUNT) begin
            fifoInData = flash[byteAddr(hdr.sector, rdIdx)];
        end else begin
            fifoInData = two_wire_flash_pkg::BLANK_BYTE;
        end
    end

    byte_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) readFifo (
        .mclk(mclk),
        .rst(rst),
        .flush(linkReset || fillStart),
        .inValid(fifoInValid),
        .inReady(fifoInReady),
        .inData(fifoInData),
        .outValid(fifoOutValid),
        .outReady(popReq),
        .outData(fifoOutData)
    );
endmodule

// ===== two_wire_flash_pkg.sv
// shared constants and types of the two-wire serial flash port
// assumes a single 10 MHz system clock; the link clock arrives as a sampled input
package two_wire_flash_pkg;
    // ========================================
    // array organisation
    localparam int SECTOR_BYTES = 536;
    localparam int SMALL_SECTORS = 2048;
    localparam int LARGE_SECTORS = 4096;
    localparam logic [15:0] INFO_SECTOR = 16'h5000;
    localparam logic [7:0] SECTOR_TAG = 8'hc9;
    localparam logic [7:0] BLANK_BYTE = 8'hff;

    // ========================================
    // status words and commands
    localparam logic [15:0] STATUS_BUSY = 16'h6666;
    localparam logic [15:0] STATUS_READY = 16'h9999;
    localparam logic [3:0] CMD_READ = 4'h3;
    localparam logic [3:0] CMD_WRITE = 4'hc;

    // ========================================
    // field lengths in link bits
    localparam int HEADER_BITS = 24;
    localparam int STATUS_BITS = 16;
    localparam int BYTE_BITS = 8;

    // ========================================
    // timing
    localparam int CLOCK_NS = 100;
    localparam int RESET_TIME_NS = 1500;
    localparam int RESET_CYC = (RESET_TIME_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam int PROGRAM_TIME_US = 30000;
    localparam int PROGRAM_CYC = PROGRAM_TIME_US * 1000 / CLOCK_NS;

    // instruction header as shifted in, command first
    typedef struct packed {
        logic [3:0] cmd;
        logic [3:0] deviceSelectField;
        logic [15:0] sector;
    } header_s;

    typedef enum {
        sStandby,
        sHeader,
        sStatus,
        sReadData,
        sWriteData,
        sIgnore
    } link_state_e;
endpackage

// ===== byte_fifo.sv
// small synchronous fifo with valid/ready on both sides and a flush
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic flush,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
    logic [PW:0] count, next_count;
    logic push, pop;

    // ========================================
    // handshake and pointer updates
    assign inReady = (count != FULL);
    assign outValid = (count != '0);
    assign outData = store[rdPtr];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_comb begin
        next_wrPtr = push ? PW'(wrPtr + 1'b1) : wrPtr;
        next_rdPtr = pop ? PW'(rdPtr + 1'b1) : rdPtr;
        next_count = count;
        if (push && !pop) begin
            next_count = (PW+1)'(count + 1'b1);
        end else if (pop && !push) begin
            next_count = (PW+1)'(count - 1'b1);
        end
        // flush drops stale words so a new sequence never sees old data
        if (flush) begin
            next_wrPtr = '0;
            next_rdPtr = '0;
            next_count = '0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            count <= next_count;
        end
    end

    // storage needs no reset
    always_ff @(posedge mclk) begin
        if (push && !flush) begin
            store[wrPtr] <= inData;
        end
    end
endmodule

// ===== two_wire_flash_host.sv
// host model of the two-wire link: drives link clock and data pin
// assumes mclk at 100 ns; all changes land at falling mclk edges
`timescale 1ns/1ns
module two_wire_flash_host (
    input wire logic mclk,
    input wire logic devOut,
    input wire logic devOe,
    output logic sck,
    output logic pinLevel
);
    logic hostOe = 1'h0;
    logic hostBit = 1'h0;
    logic floatBit = 1'h0;
    int hiHold = 4;
    localparam int STATUS_WAIT = 300; // 30 us settle after the first status rise
    // ========================================
    // wire level
    // no pull on the pin, so a released wire toggles and never looks valid
    always @(negedge mclk) floatBit <= ~floatBit;
    assign pinLevel = devOe ? devOut : (hostOe ? hostBit : floatBit);
    initial sck = 1'h0;
    // ========================================
    // link steps
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // long low resets the device, then one wake edge
    task automatic linkReset();
        sck = 1'h0;
        hostOe = 1'h0;
        tick(24);
        sck = 1'h1;
        tick(4);
    endtask
    // data set while low; seen is the pin just before the rise
    task automatic clockBit(input logic b, input logic drive, output logic seen);
        sck = 1'h0;
        hostOe = drive;
        hostBit = b;
        tick(4);
        seen = pinLevel;
        sck = 1'h1;
        tick(hiHold);
    endtask
    task automatic sendHeader(input logic [3:0] cmd, input logic [3:0] dev, input logic [15:0] sec);
        two_wire_flash_pkg::header_s h;
        logic s;
        h = '{cmd: cmd, deviceSelectField: dev, sector: sec};
        for (int i = 23; i >= 0; i--)
            clockBit(h[i], 1'h1, s);
    endtask
    task automatic sendByte(input logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            clockBit(d[i], 1'h1, s);
    endtask
    // the first status rise is followed by the settle wait, clock held high
    task automatic recvWord(output logic [15:0] w);
        for (int i = 15; i >= 0; i--) begin
            clockBit(1'h0, 1'h0, w[i]);
            if (i == 15)
                tick(STATUS_WAIT);
        end
    endtask
    task automatic recvByte(output logic [7:0] d);
        for (int i = 7; i >= 0; i--)
            clockBit(1'h0, 1'h0, d[i]);
    endtask
endmodule

// ===== two_wire_serial_flash_port_sva.sv
// port checks of the two-wire serial flash port
// assumes one mclk domain with synchronous active-high rst
`timescale 1ns/1ns
module two_wire_serial_flash_port_sva #(
    parameter int PROGRAM_CYC = 300000
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic sck,
    input wire logic bidirDataPinIn,
    input wire logic bidirDataPinOut,
    input wire logic bidirDataPinOe,
    input wire logic [3:0] deviceSelectStraps,
    input wire logic busy
);
    logic [5:0] lowCnt;
    logic [5:0] next_lowCnt;
    logic [31:0] busyCnt;
    logic [31:0] next_busyCnt;
    // ========================================
    // helper counters
    // low count saturates so a long idle never wraps into the reset window
    always_comb begin
        next_lowCnt = (rst || sck) ? 6'h00 : lowCnt + {5'h00, lowCnt != 6'h3f};
        next_busyCnt = (rst || !busy) ? 32'h0 : busyCnt + 32'h1;
    end
    always_ff @(posedge mclk) begin
        lowCnt <= next_lowCnt;
        busyCnt <= next_busyCnt;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // ========================================
    // assertions
    a_reset_quiet: assert property (disable iff (1'h0) rst |=> !bidirDataPinOe && !busy)
        else $error("pin driven or busy after reset");
    a_out_on_rise: assert property ($changed(bidirDataPinOut) && bidirDataPinOe && $past(bidirDataPinOe)
        |-> $past(sck) && !$past(sck, 2)) else $error("data bit changed off a clock rise");
    a_oe_on_rise: assert property ($rose(bidirDataPinOe) |-> $past(sck) && !$past(sck, 2))
        else $error("pin drive began off a clock rise");
    a_status_first: assert property ($rose(bidirDataPinOe) |-> bidirDataPinOut == !$past(busy))
        else $error("first status bit disagrees with busy");
    a_pause_holds: assert property (bidirDataPinOe && sck && $past(sck) |=> bidirDataPinOe)
        else $error("pin released while clock held high");
    a_short_low: assert property (bidirDataPinOe && lowCnt == 6'h08 |=> bidirDataPinOe)
        else $error("pin released by a short low clock");
    a_link_reset: assert property (lowCnt == 6'h13 |-> !bidirDataPinOe)
        else $error("pin still driven after a long low clock");
    a_busy_start: assert property ($rose(busy) |-> !sck && lowCnt inside {[6'h0e:6'h14]})
        else $error("programming began without a closing reset");
    a_busy_bound: assert property (busy |-> busyCnt < PROGRAM_CYC + 2)
        else $error("busy outlasted the program time");
endmodule

bind two_wire_serial_flash_port two_wire_serial_flash_port_sva #(.PROGRAM_CYC(PROGRAM_CYC)) chk (
    .mclk(mclk), .rst(rst), .sck(sck), .bidirDataPinIn(bidirDataPinIn), .bidirDataPinOut(bidirDataPinOut),
    .bidirDataPinOe(bidirDataPinOe), .deviceSelectStraps(deviceSelectStraps), .busy(busy));

// ===== two_wire_serial_flash_port_tb_top.sv
// self-checking bench of the two-wire serial flash port
// assumes the host model two_wire_flash_host and the bound checker
`timescale 1ns/1ns
module two_wire_serial_flash_port_tb_top;
    localparam int PROG = 2000;
    localparam int SECT = 8;
    localparam logic [15:0] ID = 16'h3c5a; // arbitrary identity value
    localparam logic [3:0] STRAPS = 4'ha;
    localparam logic [3:0] RD = two_wire_flash_pkg::CMD_READ;
    localparam logic [3:0] WR = two_wire_flash_pkg::CMD_WRITE;
    localparam logic [15:0] READY = two_wire_flash_pkg::STATUS_READY;
    localparam logic [7:0] TAG = two_wire_flash_pkg::SECTOR_TAG;
    logic mclk = 1'h0;
    logic rst = 1'h1;
    logic sck;
    logic pinLevel;
    logic devOut;
    logic devOe;
    logic busy;
    logic oeSeen = 1'h0;
    int nErrors = 0;
    int cmpCount = 0;

    two_wire_serial_flash_port #(.SECTORS(SECT), .PROGRAM_CYC(PROG), .FIFO_DEPTH(16), .DEVICE_ID(ID)) uut (
        .mclk(mclk), .rst(rst), .sck(sck), .bidirDataPinIn(pinLevel), .bidirDataPinOut(devOut),
        .bidirDataPinOe(devOe), .deviceSelectStraps(STRAPS), .busy(busy));
    two_wire_flash_host host (.mclk(mclk), .devOut(devOut), .devOe(devOe), .sck(sck), .pinLevel(pinLevel));
    // ========================================
    // clock and drive watch
    initial forever #50 mclk = ~mclk;
    // any moment of device drive leaves a mark here
    always @(posedge mclk)
        if (devOe === 1'h1)
            oeSeen = 1'h1;
    // ========================================
    // shared steps
    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        cmpCount++;
        if (got !== exp) begin
            nErrors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // bounded a little above the program time
    task automatic waitReady();
        int n;
        n = 0;
        while (busy !== 1'h0 && n < PROG + 10) begin
            @(negedge mclk);
            n++;
        end
        check("busy", 24'h0, {23'h0, busy});
    endtask
    task automatic readHead(input logic [15:0] sec, output logic [15:0] st, output logic [23:0] d);
        host.linkReset();
        host.sendHeader(RD, STRAPS, sec);
        host.recvWord(st);
        for (int i = 2; i >= 0; i--)
            host.recvByte(d[i*8 +: 8]);
    endtask
    // the closing link reset starts programming and wakes the device
    task automatic writeSector(input logic [15:0] sec, input logic [23:0] d);
        host.linkReset();
        host.sendHeader(WR, STRAPS, sec);
        for (int i = 2; i >= 0; i--)
            host.sendByte(d[i*8 +: 8]);
        host.linkReset();
    endtask
    // ========================================
    // scenarios
    task automatic testReadyRead();
        logic [15:0] st;
        logic [23:0] d;
        readHead(16'h0000, st, d);
        check("ready status", {8'h00, READY}, {8'h00, st});
        check("sector tag", {16'h0, TAG}, {16'h0, d[23:16]});
        $display("test ready read done");
    endtask
    task automatic testSelect();
        logic [15:0] w;
        for (int s = 0; s < 16; s++) begin
            host.linkReset();
            oeSeen = 1'h0;
            host.sendHeader(RD, 4'(s), 16'h0000);
            host.recvWord(w);
            check("pin driven", {23'h0, 4'(s) == STRAPS}, {23'h0, oeSeen});
        end
        $display("test select done");
    endtask
    task automatic testWriteBusy();
        logic [15:0] st;
        logic [23:0] d;
        host.hiHold = 60;
        writeSector(16'h0001, 24'ha53c0f);
        host.hiHold = 4;
        check("busy after write", 24'h1, {23'h0, busy});
        host.sendHeader(RD, STRAPS, 16'h0001);
        host.recvWord(st);
        check("busy status", {8'h00, two_wire_flash_pkg::STATUS_BUSY}, {8'h00, st});
        oeSeen = 1'h0;
        host.recvWord(st);
        check("pin after busy status", 24'h0, {23'h0, oeSeen});
        waitReady();
        readHead(16'h0001, st, d);
        check("written data", 24'ha53c0f, d);
        $display("test write busy done");
    endtask
    task automatic testInfo();
        logic [15:0] st;
        logic [23:0] d;
        logic [15:0] secs [3];
        secs = '{two_wire_flash_pkg::INFO_SECTOR, 16'(SECT - 2), 16'(SECT - 1)};
        for (int i = 0; i < 3; i++) begin
            writeSector(secs[i], 24'h000000);
            waitReady();
            readHead(secs[i], st, d);
            check("info contents", {TAG, ID}, d);
        end
        // an unguarded info write would wrap onto the start of sector 0
        readHead(16'h0000, st, d);
        check("tag kept", {16'h0, TAG}, {16'h0, d[23:16]});
        $display("test info done");
    endtask
    // ========================================
    // run and verdict
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmpCount, nErrors);
        if (nErrors == 0 && cmpCount > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge mclk);
        rst = 1'h0;
        testReadyRead();
        testSelect();
        testWriteBusy();
        testInfo();
        summarize();
    end
    // the tests need about 30k cycles, so this only cuts a hang
    initial begin
        repeat (60000) @(posedge mclk);
        nErrors++;
        $display("watchdog expired");
        summarize();
    end
endmodule
